// ### hdl/sbo_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RULE1] burst type bit picks sequential or interleaved
// [RULE2] burst length from two lowest mode bits
// [RULE3] per-command mode samples address bit 12
// [RULE4] sequential read rotates within column-bit-2 group
// [RULE5] interleaved read position is beat xor column
// [RULE6] chopped read tristates the last four slots
// [RULE7] chopped write starts at 0 or 4
// [RULE8] eight-beat write stores ascending from zero
// [RULE9] fixed chop starts internal write two clocks early
// [RULE10] per-command chop keeps eight-beat write start
// [RULE11] controller programs write recovery at least minimum
// [RULE12] crc error with masking aborts the write
// [RULE13] controller programs read-to-precharge at least minimum
// [RULE14] mode set with select 001 hits register one
// [RULE15] bit 0 of register one enables the dll
// [RULE16] bit 12 of register one disconnects outputs
// [RULE17] added latency field, nonzero unsupported here
// [RULE18] controller writes zero to reserved bits
// [RULE19] burst length codes eight, otf, chop, reserved
// [RULE20] bits 2:1 select output drive strength
// [RULE21] bits 10:8 select nominal termination
// [RULE22] bit 7 enables write leveling

////////////////////////////////////////////////////////////////////////
// write data fifo, stalls the source when full
module sbo_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,              // clock
    input wire logic rst_i,              // sync reset, high
    input wire logic en_i,               // clock enable
    input wire logic [WIDTH-1:0] in_data_i, // fill data
    input wire logic in_valid_i,         // fill valid
    output logic in_ready_o,             // fill ready
    output logic [WIDTH-1:0] out_data_o, // drain data
    output logic out_valid_o,            // drain valid
    input wire logic out_ready_i         // drain ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];     // storage
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d; // pointers
    logic [AW:0] cnt_q, cnt_d;           // fill level
    logic full_q, full_d, empty_q, empty_d; // registered flags
    logic push, pop;                     // handshakes

    // next pointers and flags
    always_comb begin
        push = in_valid_i && !full_q;
        pop = out_ready_i && !empty_q;
        wp_d = wp_q;
        rp_d = rp_q;
        if (push) begin
            wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
        end
        if (pop) begin
            rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
        end
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        full_d = (cnt_d == (AW+1)'(DEPTH));
        empty_d = (cnt_d == '0);
    end

    // register pointers; storage has no reset on purpose
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
        end else if (en_i) begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            full_q <= full_d;
            empty_q <= empty_d;
            if (push) begin
                mem_q[wp_q] <= in_data_i;
            end
        end
    end

    assign in_ready_o = !full_q;
    assign out_valid_o = !empty_q;
    assign out_data_o = mem_q[rp_q];
endmodule

////////////////////////////////////////////////////////////////////////
// burst ordering and mode register one decode
module sbo_top #(
    parameter int WR_START_CYC = 8,      // command to internal write, eight-beat
    parameter logic [7:0] PRE_CYC = 8'h08, // precharge_time in clocks
    parameter int FIFO_DEPTH = 32        // write data fifo depth
) (
    input wire logic ref_clk_i,          // 125 MHz clock
    input wire logic sys_rst_i,          // sync reset, high
    input wire logic clk_en_i,           // freezes all state when low
    input wire sbo_pkg::sbo_cmd_t cmd_i, // registered command
    input wire logic dm_en_i,            // write_byte_mask enabled
    input wire logic crc_en_i,           // write crc enabled
    input wire logic crc_err_i,          // crc mismatch on current write
    input wire logic [sbo_pkg::SBO_DATA_W-1:0] wdata_i, // write beat
    input wire logic wdata_valid_i,      // write beat valid
    output logic wdata_ready_o,          // fifo has room
    output logic [sbo_pkg::SBO_DATA_W-1:0] rd_data_o, // read beat
    output logic [2:0] rd_pos_o,         // word position of beat
    output logic rd_data_oe_o,           // dq driven
    output logic rd_strobe_oe_o,         // strobe driven
    output sbo_pkg::sbo_cfg_t cfg_o,     // decoded register one
    output logic intl_write_o,           // internal write start pulse
    output logic wr_abort_o,             // write dropped pulse
    output logic dal_busy_o,             // auto precharge write delay running
    output logic act_block_o,            // read to precharge plus precharge
    output logic busy_o                  // burst in progress
);
    import sbo_pkg::*;

    typedef enum {SBO_IDLE, SBO_READ, SBO_WRITE, SBO_COMMIT} sbo_state_t;

    sbo_state_t st_q, st_d;              // burst state
    logic [2:0] beat_q, beat_d;          // beat index
    logic [2:0] col_q, col_d;            // start column bits
    logic chop_q, chop_d;                // four-beat chop
    logic ilv_q, ilv_d;                  // interleaved order
    logic [SBO_ADDR_W-1:0] mr0_q, mr0_d; // mode_reg_zero
    logic [SBO_ADDR_W-1:0] mr1_q, mr1_d; // mode_reg_one
    logic [SBO_DATA_W-1:0] row_q [8];    // open row words
    logic [SBO_DATA_W-1:0] row_d [8];
    logic [SBO_DATA_W-1:0] stg_q [8];    // staged write words
    logic [SBO_DATA_W-1:0] stg_d [8];
    logic [7:0] smask_q, smask_d;        // staged word valid
    logic [7:0] start_q, start_d;        // internal write countdown
    logic [7:0] dal_q, dal_d;            // write delay countdown
    logic [7:0] rtp_q, rtp_d;            // read to activate countdown
    logic [SBO_DATA_W-1:0] rdat_d;
    logic [2:0] pos_d;
    logic oe_d, iw_d, ab_d;
    sbo_cfg_t cfg_d;
    logic [SBO_DATA_W-1:0] f_data;       // fifo drain side
    logic f_valid, f_ready;
    logic [2:0] msel;                    // mode register select
    logic mode_reg_set_cmd, take_rd, take_wr, fixed_chop, abort;
    logic [2:0] wr_code;
    logic [7:0] wr_cyc, rtp_cyc;

    ////////////////////////////////////////////////////////////////////
    // write data buffer between pins and the staging words
    sbo_fifo #(
        .WIDTH(SBO_DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(ref_clk_i),
        .rst_i(sys_rst_i),
        .en_i(clk_en_i),
        .in_data_i(wdata_i),
        .in_valid_i(wdata_valid_i),
        .in_ready_o(wdata_ready_o),
        .out_data_o(f_data),
        .out_valid_o(f_valid),
        .out_ready_i(f_ready)
    );

    ////////////////////////////////////////////////////////////////////
    // command decode and setting lookups
    always_comb begin
        msel = {cmd_i.bg0, cmd_i.ba};
        mode_reg_set_cmd = (cmd_i.kind == SBO_CMD_MRS);
        // new bursts only from idle with no write start pending
        take_rd = (cmd_i.kind == SBO_CMD_RD) && (st_q == SBO_IDLE) && (start_q == '0);
        take_wr = (cmd_i.kind == SBO_CMD_WR) && (st_q == SBO_IDLE) && (start_q == '0);
        fixed_chop = (mr0_q[SBO_MR0_BL_LSB +: 2] == SBO_BL_CHOP); // see [RULE19]
        // reserved codes clamp to the longest setting
        wr_code = (mr0_q[SBO_MR0_WR_LSB +: 3] > SBO_WR_CODE_MAX) ? SBO_WR_CODE_MAX
                                                                  : mr0_q[SBO_MR0_WR_LSB +: 3];
        wr_cyc = SBO_WR_BASE + {4'h0, wr_code, 1'b0};
        rtp_cyc = SBO_RTP_BASE + {5'h00, wr_code};
        abort = dm_en_i && crc_en_i && crc_err_i; // see [RULE12]
        f_ready = (st_q == SBO_WRITE);
    end

    ////////////////////////////////////////////////////////////////////
    // next state of bursts, mode registers and timers
    always_comb begin
        st_d = st_q;
        beat_d = beat_q;
        col_d = col_q;
        chop_d = chop_q;
        ilv_d = ilv_q;
        mr0_d = mr0_q;
        mr1_d = mr1_q;
        row_d = row_q;
        stg_d = stg_q;
        smask_d = smask_q;
        start_d = (start_q != '0) ? start_q - 8'h01 : start_q;
        dal_d = (dal_q != '0) ? dal_q - 8'h01 : dal_q;
        rtp_d = (rtp_q != '0) ? rtp_q - 8'h01 : rtp_q;
        iw_d = 1'b0;
        ab_d = 1'b0;
        oe_d = 1'b0;
        pos_d = '0;
        rdat_d = '0;
        // mode register writes, register one only on select 001
        if (mode_reg_set_cmd && msel == SBO_SEL_MR0) begin
            mr0_d = cmd_i.addr;
        end
        if (mode_reg_set_cmd && msel == SBO_SEL_MR1) begin
            mr1_d = cmd_i.addr; // see [RULE14]
        end
        // internal write start fires as the countdown expires
        if (start_q == 8'h01) begin
            iw_d = 1'b1;
            dal_d = wr_cyc + PRE_CYC; // auto_precharge_write_delay
        end
        // burst length and type latched per command
        if (take_rd || take_wr) begin
            col_d = cmd_i.addr[2:0];
            beat_d = '0;
            ilv_d = mr0_q[SBO_MR0_BT_BIT]; // see [RULE1]
            unique case (mr0_q[SBO_MR0_BL_LSB +: 2]) // see [RULE2]
                SBO_BL_OTF: chop_d = !cmd_i.addr[SBO_CHOP_PIN_BIT]; // see [RULE3]
                SBO_BL_CHOP: chop_d = 1'b1;
                default: chop_d = 1'b0; // eight-beat and the reserved code
            endcase
        end
        if (take_rd) begin
            st_d = SBO_READ;
            rtp_d = rtp_cyc + PRE_CYC;
        end
        if (take_wr) begin
            st_d = SBO_WRITE;
            smask_d = '0;
            // fixed chop pulls the start in, per-command chop does not
            start_d = 8'(WR_START_CYC) - (fixed_chop ? SBO_BC4_PULL_IN : 8'h00); // see [RULE9] [RULE10]
        end
        unique case (st_q)
            SBO_IDLE: begin
            end
            SBO_READ: begin
                // word position for this beat
                if (ilv_q) begin
                    pos_d = beat_q ^ col_q; // see [RULE5]
                end else begin
                    pos_d = {col_q[2] ^ beat_q[2], col_q[1:0] + beat_q[1:0]}; // see [RULE4]
                end
                rdat_d = row_q[pos_d];
                // chop leaves the second half of the slots undriven
                oe_d = !(chop_q && beat_q[2]) && !mr1_q[SBO_MR1_QOFF_BIT]; // see [RULE6] [RULE16]
                beat_d = beat_q + 3'h1;
                if (beat_q == 3'h7) begin
                    st_d = SBO_IDLE;
                end
            end
            SBO_WRITE: begin
                // all eight beats are drained so the bus stays aligned
                if (f_valid) begin
                    if (!chop_q) begin
                        stg_d[beat_q] = f_data; // see [RULE8]
                        smask_d[beat_q] = 1'b1;
                    end else if (!beat_q[2]) begin
                        stg_d[{col_q[2], beat_q[1:0]}] = f_data; // see [RULE7]
                        smask_d[{col_q[2], beat_q[1:0]}] = 1'b1;
                    end
                    beat_d = beat_q + 3'h1;
                    if (beat_q == 3'h7) begin
                        st_d = SBO_COMMIT;
                    end
                end
            end
            SBO_COMMIT: begin
                // crc is judged before anything reaches the row
                if (abort) begin
                    ab_d = 1'b1; // see [RULE12]
                end else begin
                    for (int i = 0; i < 8; i++) begin
                        if (smask_q[i]) begin
                            row_d[i] = stg_q[i];
                        end
                    end
                end
                st_d = SBO_IDLE;
            end
        endcase
        // decoded register one view
        cfg_d.dll_en = mr1_q[SBO_MR1_DLL_BIT]; // see [RULE15]
        cfg_d.qoff = mr1_q[SBO_MR1_QOFF_BIT]; // see [RULE16]
        cfg_d.drive = mr1_q[SBO_MR1_DRV_LSB +: 2]; // see [RULE20]
        cfg_d.drive_reserved = mr1_q[SBO_MR1_DRV_LSB + 1]; // see [RULE20]
        cfg_d.nominal_termination = mr1_q[SBO_MR1_RTT_LSB +: 3]; // see [RULE21]
        cfg_d.write_leveling_enable = mr1_q[SBO_MR1_WLEV_BIT]; // see [RULE22]
        cfg_d.added_command_latency = mr1_q[SBO_MR1_AL_LSB +: 2]; // see [RULE17]
        // no added latency on this width; flagged, timing stays at zero
        cfg_d.latency_unsupported = (mr1_q[SBO_MR1_AL_LSB +: 2] != 2'h0); // see [RULE17]
    end

    ////////////////////////////////////////////////////////////////////
    // state registers, frozen while the clock enable is low
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st_q <= SBO_IDLE;
            beat_q <= '0;
            col_q <= '0;
            chop_q <= 1'b0;
            ilv_q <= 1'b0;
            mr0_q <= SBO_MR0_RST;
            mr1_q <= SBO_MR1_RST;
            smask_q <= '0;
            start_q <= '0;
            dal_q <= '0;
            rtp_q <= '0;
            rd_data_o <= '0;
            rd_pos_o <= '0;
            rd_data_oe_o <= 1'b0;
            rd_strobe_oe_o <= 1'b0;
            cfg_o <= '0;
            intl_write_o <= 1'b0;
            wr_abort_o <= 1'b0;
            dal_busy_o <= 1'b0;
            act_block_o <= 1'b0;
            busy_o <= 1'b0;
        end else if (clk_en_i) begin
            st_q <= st_d;
            beat_q <= beat_d;
            col_q <= col_d;
            chop_q <= chop_d;
            ilv_q <= ilv_d;
            mr0_q <= mr0_d;
            mr1_q <= mr1_d;
            smask_q <= smask_d;
            start_q <= start_d;
            dal_q <= dal_d;
            rtp_q <= rtp_d;
            rd_data_o <= rdat_d;
            rd_pos_o <= pos_d;
            rd_data_oe_o <= oe_d;
            rd_strobe_oe_o <= oe_d;
            cfg_o <= cfg_d;
            intl_write_o <= iw_d;
            wr_abort_o <= ab_d;
            dal_busy_o <= (dal_d != '0);
            act_block_o <= (rtp_d != '0);
            busy_o <= (st_d != SBO_IDLE);
        end
    end

    // array words carry no reset; contents are undefined until written
    always_ff @(posedge ref_clk_i) begin
        if (clk_en_i) begin
            row_q <= row_d;
            stg_q <= stg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i || !clk_en_i);
    // the pulse is registered one edge after the countdown reaches one
    localparam int AST_FIX_D = WR_START_CYC - 1;
    localparam int AST_OTF_D = WR_START_CYC + 1;

    AST_DLL_FOLLOWS: assert property ( // see [RULE15]
        (mode_reg_set_cmd && msel == SBO_SEL_MR1) |-> ##2 cfg_o.dll_en == $past(cmd_i.addr[0], 2))
        else $error("dll enable does not follow register one bit 0");
    AST_QOFF_QUIET: assert property ( // see [RULE16]
        cfg_o.qoff |-> !rd_data_oe_o && !rd_strobe_oe_o)
        else $error("outputs driven while disconnected");
    AST_MR_SELECT: assert property ( // see [RULE14]
        (mode_reg_set_cmd && msel != SBO_SEL_MR1) |=> mr1_q == $past(mr1_q))
        else $error("register one written with wrong select");
    AST_CHOP_TRISTATE: assert property ( // see [RULE6]
        (st_q == SBO_READ && chop_q && beat_q[2]) |=> !rd_data_oe_o && !rd_strobe_oe_o)
        else $error("chopped read drives a tail slot");
    AST_SEQ_WRAP: assert property ( // see [RULE4]
        (st_q == SBO_READ && !ilv_q && beat_q == 3'h0) |=> rd_pos_o == $past(col_q)
            ##4 rd_pos_o == ($past(col_q, 5) ^ 3'h4))
        else $error("sequential order wrong");
    AST_ILV_ORDER: assert property ( // see [RULE5]
        (st_q == SBO_READ && ilv_q && beat_q == 3'h3) |=> rd_pos_o == ($past(col_q) ^ 3'h3))
        else $error("interleaved order wrong");
    AST_FIXED_START: assert property ( // see [RULE9]
        (take_wr && fixed_chop) |-> ##AST_FIX_D intl_write_o)
        else $error("fixed chop internal write not two clocks early");
    AST_OTF_START: assert property ( // see [RULE10]
        (take_wr && !fixed_chop) |-> ##AST_OTF_D intl_write_o)
        else $error("internal write start pulled in");
    AST_CRC_DROP: assert property ( // see [RULE12]
        (st_q == SBO_COMMIT && abort) |=> wr_abort_o && row_q[0] == $past(row_q[0]))
        else $error("write committed despite crc error");
    AST_CHOP_UPPER: assert property ( // see [RULE7]
        (st_q == SBO_COMMIT && chop_q && col_q[2]) |=> row_q[0] == $past(row_q[0]))
        else $error("upper chop write touched lower group");
    AST_LATENCY_FLAG: assert property ( // see [RULE17]
        (cfg_o.added_command_latency != 2'h0) |-> cfg_o.latency_unsupported)
        else $error("nonzero added latency not flagged");
endmodule
`default_nettype wire

// ### inc/sbo_pkg.sv
`default_nettype none
package sbo_pkg;
    // command kinds seen on the command/address bus
    typedef enum logic [1:0] {SBO_CMD_NOP, SBO_CMD_MRS, SBO_CMD_RD, SBO_CMD_WR} sbo_cmd_kind_t;
    localparam int SBO_ADDR_W = 17;
    localparam int SBO_DATA_W = 16;
    // one registered command with its bank and address pins
    typedef struct packed {
        sbo_cmd_kind_t kind;
        logic bg0;
        logic [1:0] ba;
        logic [SBO_ADDR_W-1:0] addr;
    } sbo_cmd_t;
    // mode register select, ordered bg0, ba1, ba0
    localparam logic [2:0] SBO_SEL_MR0 = 3'h0;
    localparam logic [2:0] SBO_SEL_MR1 = 3'h1;
    localparam logic [SBO_ADDR_W-1:0] SBO_MR0_RST = 17'h00000;
    localparam logic [SBO_ADDR_W-1:0] SBO_MR1_RST = 17'h00000;
    // mode_reg_zero fields
    localparam int SBO_MR0_BL_LSB = 0;
    localparam int SBO_MR0_BT_BIT = 3;
    localparam int SBO_MR0_WR_LSB = 9;
    // mode_reg_one fields
    localparam int SBO_MR1_DLL_BIT = 0;
    localparam int SBO_MR1_DRV_LSB = 1;
    localparam int SBO_MR1_AL_LSB = 3;
    localparam int SBO_MR1_WLEV_BIT = 7;
    localparam int SBO_MR1_RTT_LSB = 8;
    localparam int SBO_MR1_QOFF_BIT = 12;
    // chop_select_pin rides on address bit 12, low selects four_beat_chop
    localparam int SBO_CHOP_PIN_BIT = 12;
    // burst length field codes
    localparam logic [1:0] SBO_BL_EIGHT = 2'h0;
    localparam logic [1:0] SBO_BL_OTF = 2'h1;
    localparam logic [1:0] SBO_BL_CHOP = 2'h2;
    // write recovery and read to precharge setting decode
    localparam logic [2:0] SBO_WR_CODE_MAX = 3'h5;
    localparam logic [7:0] SBO_WR_BASE = 8'h0A;
    localparam logic [7:0] SBO_RTP_BASE = 8'h05;
    // internal write start pull-in for fixed chop, in clocks
    localparam logic [7:0] SBO_BC4_PULL_IN = 8'h02;
    // decoded mode_reg_one view
    typedef struct packed {
        logic dll_en;
        logic qoff;
        logic [1:0] drive;
        logic [2:0] nominal_termination;
        logic write_leveling_enable;
        logic [1:0] added_command_latency;
        logic latency_unsupported;
        logic drive_reserved;
    } sbo_cfg_t;
endpackage
`default_nettype wire

// ### dv/sbo_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// controller stand-in: drives commands and write beats
module sbo_ctrl_model #(
    parameter logic [2:0] MIN_CODE = 3'h0 // least recovery code the part needs
) (
    input wire logic clk_i, // bench clock
    input wire logic ready_i, // fifo has room
    output sbo_pkg::sbo_cmd_t cmd_o, // command bus
    output logic [sbo_pkg::SBO_DATA_W-1:0] wdata_o, // write beat
    output logic wdata_valid_o // beat valid
);
    import sbo_pkg::*;
    // idle bus at time zero
    initial begin
        cmd_o = '0;
        wdata_o = '0;
        wdata_valid_o = 1'b0;
    end
    ////////////////////////////////////////
    // one command cycle; idle pins inverted so a stale value never looks valid
    task automatic issue(input sbo_cmd_kind_t kind, input logic [2:0] sel, input logic [SBO_ADDR_W-1:0] a);
        @(posedge clk_i);
        cmd_o <= '{kind, sel[2], sel[1:0], a};
        @(posedge clk_i);
        cmd_o <= '{SBO_CMD_NOP, ~sel[2], ~sel[1:0], ~a};
    endtask
    // register one, reserved bits forced to zero
    task automatic set_one(input logic [SBO_ADDR_W-1:0] v);
        issue(SBO_CMD_MRS, SBO_SEL_MR1, v & 17'h0179F);
    endtask
    // register zero, recovery code never below the minimum
    task automatic set_zero(input logic [SBO_ADDR_W-1:0] v);
        logic [SBO_ADDR_W-1:0] m;
        m = v;
        if (m[11:9] < MIN_CODE) m[11:9] = MIN_CODE;
        issue(SBO_CMD_MRS, SBO_SEL_MR0, m & 17'h00E0B);
    endtask
    // hold the beat until the fifo takes it
    task automatic push(input logic [SBO_DATA_W-1:0] d);
        @(posedge clk_i);
        wdata_o <= d;
        wdata_valid_o <= 1'b1;
        do @(posedge clk_i); while (ready_i !== 1'b1);
        wdata_valid_o <= 1'b0;
        wdata_o <= ~d;
    endtask
endmodule
`default_nettype wire

// ### dv/sbo_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module sbo_top_test;
    import sbo_pkg::*;
    localparam int NW = 4; // short write start keeps the run brief
    localparam logic [7:0] PRE = 8'h02; // short precharge
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic mask_en = 1'b0;
    logic crc_en = 1'b0;
    logic crc_err = 1'b0;
    sbo_cmd_t cmd;
    sbo_cfg_t cfg, cfg_e;
    logic [SBO_DATA_W-1:0] wdata, rd_data;
    logic [2:0] rd_pos;
    logic wvalid, wready, rd_oe, st_oe, intl, abort_p, rec, act, busy;
    integer fail_count = 0;
    integer tests_run = 0;
    integer cycles = 0;
    integer seed = 32'hd48c;
    integer intl_at, abort_n, rec_n, act_n;
    logic [SBO_DATA_W-1:0] mem [8]; // expected row contents
    logic [SBO_DATA_W-1:0] wq [$]; // beats waiting in the fifo
    logic [2:0] pos_s [9];
    logic [1:0] oe_s [9];
    logic [SBO_DATA_W-1:0] dat_s [9];
    always #4 ref_clk = ~ref_clk;
    sbo_top #(.WR_START_CYC(NW), .PRE_CYC(PRE), .FIFO_DEPTH(32)) dut_u (
        .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .clk_en_i(clk_en), .cmd_i(cmd),
        .dm_en_i(mask_en), .crc_en_i(crc_en), .crc_err_i(crc_err), .wdata_i(wdata),
        .wdata_valid_i(wvalid), .wdata_ready_o(wready), .rd_data_o(rd_data), .rd_pos_o(rd_pos),
        .rd_data_oe_o(rd_oe), .rd_strobe_oe_o(st_oe), .cfg_o(cfg), .intl_write_o(intl),
        .wr_abort_o(abort_p), .dal_busy_o(rec), .act_block_o(act), .busy_o(busy));
    sbo_ctrl_model ctrl_u (.clk_i(ref_clk), .ready_i(wready), .cmd_o(cmd), .wdata_o(wdata),
        .wdata_valid_o(wvalid));
    ////////////////////////////////////////
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // sample every cycle after a command is taken
    task automatic watch(input integer n);
        intl_at = 0;
        abort_n = 0;
        rec_n = 0;
        // the block rises on the take edge itself, so count that cycle too
        #1;
        act_n = act;
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            #1;
            if (i < 9) begin
                pos_s[i] = rd_pos;
                oe_s[i] = {st_oe, rd_oe};
                dat_s[i] = rd_data;
            end
            if (intl === 1'b1 && intl_at == 0) intl_at = i + 1;
            abort_n = abort_n + abort_p;
            rec_n = rec_n + rec;
            act_n = act_n + act;
        end
    endtask
    // register one write and decoded view after two edges
    task automatic one(input logic [16:0] v);
        ctrl_u.set_one(v);
        repeat (2) @(posedge ref_clk);
        #1;
        cfg_e = '{v[0], v[12], v[2:1], v[10:8], v[7], v[4:3], |v[4:3], v[2]};
        check("mode one", cfg, cfg_e);
    endtask
    ////////////////////////////////////////
    // one write burst; an abort leaves the row alone
    task automatic wr(input logic [2:0] col, input logic pin, input logic [1:0] len, input logic [2:0] code);
        logic chop;
        logic [SBO_DATA_W-1:0] w;
        chop = (len == SBO_BL_CHOP) || (len == SBO_BL_OTF && !pin);
        while (wq.size() < 8) begin
            w = 16'($random(seed));
            wq.push_back(w);
            ctrl_u.push(w);
        end
        mask_en <= 1'($random(seed));
        crc_en <= 1'($random(seed));
        // no abort until the row is known, so reads never compare against unknowns
        crc_err <= 1'($random(seed)) & !$isunknown(mem[0]);
        ctrl_u.issue(SBO_CMD_WR, 3'h0, {4'h0, pin, 9'h000, col});
        watch(40);
        check("write start", intl_at, (len == SBO_BL_CHOP) ? NW - 2 : NW);
        check("write abort", abort_n, mask_en & crc_en & crc_err);
        check("write recovery", rec_n, 10 + 2 * code + PRE);
        for (int i = 0; i < 8; i++) begin
            w = wq.pop_front();
            if (!(mask_en & crc_en & crc_err) && (!chop || i < 4)) mem[chop ? {col[2], i[1:0]} : i[2:0]] = w;
        end
    endtask
    // one read burst against the expected order
    task automatic rd(input logic [2:0] col, input logic pin, input logic [1:0] len, input logic bt,
        input logic [2:0] code, input logic qoff);
        logic chop;
        logic [2:0] p;
        chop = (len == SBO_BL_CHOP) || (len == SBO_BL_OTF && !pin);
        ctrl_u.issue(SBO_CMD_RD, 3'h0, {4'h0, pin, 9'h000, col});
        watch(30);
        check("read precharge", act_n, 5 + code + PRE);
        for (int i = 0; i < 9; i++) begin
            p = bt ? col ^ i[2:0] : {col[2] ^ i[2], col[1:0] + i[1:0]};
            check("read oe", oe_s[i], {2{i < (chop ? 4 : 8) && !qoff}});
            if (i < 8 && (!chop || i < 4) && !qoff) begin
                check("read pos", pos_s[i], p);
                check("read data", dat_s[i], mem[p]);
            end
        end
    endtask
    ////////////////////////////////////////
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            conclude();
        end
    end
    initial begin
        logic [1:0] len;
        logic [2:0] code;
        logic [31:0] rv;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        check("reset cfg", cfg, 32'h0);
        check("reset ready", {busy, wready}, 32'h1);
        one(17'h0101C);
        for (int i = 0; i < 6; i++) one(17'($random(seed)) & 17'h0179F);
        one(17'h00001);
        // frozen clock enable must ignore a register write
        @(posedge ref_clk);
        clk_en <= 1'b0;
        ctrl_u.set_one(17'h00081);
        repeat (2) @(posedge ref_clk);
        clk_en <= 1'b1;
        #1;
        check("frozen cfg", cfg, cfg_e);
        // every length code with both orders
        for (int i = 0; i < 16; i++) begin
            len = i[2:1];
            code = 3'($unsigned($random(seed)) % 6);
            rv = $random(seed);
            ctrl_u.set_zero({5'h00, code, 5'h00, i[0], 1'b0, len});
            wr(rv[2:0], rv[3], len, code);
            check("mode one kept", cfg, cfg_e);
            rd(rv[6:4], rv[7], len, i[0], code, 1'b0);
        end
        one(17'h01001);
        rd(rv[10:8], rv[11], len, 1'b1, code, 1'b1);
        // fill the fifo until it refuses, then drain it by writes
        for (int i = 0; i < 32; i++) begin
            wq.push_back(16'($random(seed)));
            ctrl_u.push(wq[i]);
        end
        #1;
        check("fifo full", wready, 1'b0);
        one(17'h00001);
        for (int i = 0; i < 4; i++) wr(rv[2:0], rv[3], len, code);
        check("fifo empty", wready, 1'b1);
        rd(rv[6:4], rv[7], len, 1'b1, code, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
